// ---- rtl/set_and_rotate_exec.sv ----
// execution block for the set-all-ones and plain rotate-right file register instructions
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.svh"
module set_and_rotate_exec #(
  parameter int FILE_AW = `FILE_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy_o
);
  exec_pkg::exec_state_t state_ff, nxt_state;
  exec_pkg::exec_op_t op_ff, nxt_op;
  logic [15:0] instr_ff, nxt_instr;
  logic [7:0] wreg_ff, nxt_wreg;
  logic [4:0] status_ff, nxt_status;
  logic ill_ff, nxt_ill;
  logic [3:0] bank_ff, nxt_bank;
  logic ext_ff, nxt_ext;
  logic [11:0] index_ff, nxt_index;
  logic [11:0] faddr_ff, nxt_faddr;
  logic [11:0] ea_ff, nxt_ea;
  logic [7:0] operand_ff, nxt_operand;
  logic [7:0] result_ff, nxt_result;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [31:0] cur_val, sel_mask, merged;
  logic bus_req, bus_wr, dest_file;
  logic [7:0] f_adr;

  file_port_if #(.AW(FILE_AW)) fp ();

  file_regs #(.AW(FILE_AW)) u_file (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fp(fp)
  );

  assign f_adr = instr_ff[7:0];
  assign dest_file = (op_ff == exec_pkg::OP_SET) || instr_ff[9];
  assign busy_o = (state_ff != exec_pkg::ST_IDLE);
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign bus_req = wb_cyc_i && wb_stb_i;
  // write lands on the edge where the master sees ack
  assign bus_wr = bus_req && wb_we_i && ack_ff;
  assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign merged = (cur_val & ~sel_mask) | (wb_dat_i & sel_mask);

  // the store has one port, so the bus window only while idle
  assign fp.addr = busy_o ? ea_ff[FILE_AW-1:0] : faddr_ff[FILE_AW-1:0];
  assign fp.we = (state_ff == exec_pkg::ST_WRITE) ? dest_file :
                 (bus_wr && wb_adr_i == `OFS_FDATA && wb_sel_i[0]);
  assign fp.wdata = busy_o ? result_ff : wb_dat_i[7:0];

  always_comb begin
    cur_val = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_INSTR: cur_val = {16'h0000, instr_ff};
      `OFS_WREG: cur_val = {24'h00_0000, wreg_ff};
      `OFS_STATUS: cur_val = {22'h00_0000, ill_ff, busy_o, 3'h0, status_ff};
      `OFS_BANK: cur_val = {28'h000_0000, bank_ff};
      `OFS_CTRL: cur_val = {31'h0000_0000, ext_ff};
      `OFS_INDEX: cur_val = {20'h0_0000, index_ff};
      `OFS_FADDR: cur_val = {20'h0_0000, faddr_ff};
      `OFS_FDATA: cur_val = {24'h00_0000, fp.rdata};
      default: cur_val = 32'h0000_0000;
    endcase
  end

  // bus answers one cycle after the request, held off while executing
  always_comb begin
    nxt_ack = bus_req && !ack_ff && !busy_o;
    nxt_dat = nxt_ack ? cur_val : dat_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_instr = instr_ff;
    nxt_wreg = wreg_ff;
    nxt_status = status_ff;
    nxt_ill = ill_ff;
    nxt_bank = bank_ff;
    nxt_ext = ext_ff;
    nxt_index = index_ff;
    nxt_faddr = faddr_ff;
    nxt_ea = ea_ff;
    nxt_operand = operand_ff;
    nxt_result = result_ff;
    unique case (state_ff)
      exec_pkg::ST_IDLE: begin
        if (bus_wr) begin
          unique case (wb_adr_i)
            `OFS_INSTR: begin
              nxt_instr = merged[15:0];
              nxt_state = exec_pkg::ST_DECODE;
            end
            `OFS_WREG: nxt_wreg = merged[7:0];
            `OFS_STATUS: begin
              nxt_status = merged[4:0];
              // write one to clear
              if (wb_sel_i[1] && wb_dat_i[`ST_ILL_BIT]) begin
                nxt_ill = 1'b0;
              end
            end
            `OFS_BANK: nxt_bank = merged[3:0];
            `OFS_CTRL: nxt_ext = merged[`CTRL_EXT_BIT];
            `OFS_INDEX: nxt_index = merged[11:0];
            `OFS_FADDR: nxt_faddr = merged[11:0];
            default: nxt_state = state_ff;
          endcase
        end
      end
      exec_pkg::ST_DECODE: begin
        if (instr_ff[15:9] == `PAT_SET_ALL) begin
          nxt_op = exec_pkg::OP_SET;
        end else if (instr_ff[15:10] == `PAT_ROT_RIGHT) begin
          nxt_op = exec_pkg::OP_ROT;
        end else begin
          nxt_op = exec_pkg::OP_NONE;
        end
        if (instr_ff[8]) begin
          nxt_ea = {bank_ff, f_adr};
        end else if (ext_ff && f_adr <= `INDEX_LIMIT) begin
          nxt_ea = index_ff + {4'h0, f_adr};
        end else if (f_adr <= `INDEX_LIMIT) begin
          nxt_ea = {`ACCESS_LOW_PAGE, f_adr};
        end else begin
          nxt_ea = {`ACCESS_HIGH_PAGE, f_adr};
        end
        // unknown opcode: flag it and drop out, nothing written
        if (nxt_op == exec_pkg::OP_NONE) begin
          nxt_ill = 1'b1;
          nxt_state = exec_pkg::ST_IDLE;
        end else begin
          nxt_state = exec_pkg::ST_READ;
        end
      end
      exec_pkg::ST_READ: begin
        nxt_operand = fp.rdata;
        nxt_state = exec_pkg::ST_PROCESS;
      end
      exec_pkg::ST_PROCESS: begin
        if (op_ff == exec_pkg::OP_SET) begin
          nxt_result = `ALL_ONES;
        end else begin
          nxt_result = {operand_ff[0], operand_ff[7:1]};
        end
        nxt_state = exec_pkg::ST_WRITE;
      end
      exec_pkg::ST_WRITE: begin
        if (!dest_file) begin
          nxt_wreg = result_ff;
        end
        if (op_ff == exec_pkg::OP_ROT) begin
          nxt_status[`ST_N_BIT] = result_ff[7];
          nxt_status[`ST_Z_BIT] = (result_ff == 8'h00);
        end
        nxt_state = exec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= exec_pkg::ST_IDLE;
      op_ff <= exec_pkg::OP_NONE;
      instr_ff <= `RST_INSTR;
      wreg_ff <= `RST_WREG;
      status_ff <= `RST_STATUS;
      ill_ff <= 1'b0;
      bank_ff <= `RST_BANK;
      ext_ff <= 1'b0;
      index_ff <= `RST_INDEX;
      faddr_ff <= `RST_FADDR;
      ea_ff <= 12'h000;
      operand_ff <= 8'h00;
      result_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      instr_ff <= nxt_instr;
      wreg_ff <= nxt_wreg;
      status_ff <= nxt_status;
      ill_ff <= nxt_ill;
      bank_ff <= nxt_bank;
      ext_ff <= nxt_ext;
      index_ff <= nxt_index;
      faddr_ff <= nxt_faddr;
      ea_ff <= nxt_ea;
      operand_ff <= nxt_operand;
      result_ff <= nxt_result;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  set_value_a: assert property (
    state_ff == exec_pkg::ST_WRITE && op_ff == exec_pkg::OP_SET |->
      fp.we && fp.wdata == 8'hFF && fp.addr == ea_ff[FILE_AW-1:0])
    else $error("set did not write all ones");
  bank_pick_a: assert property (
    state_ff == exec_pkg::ST_DECODE && instr_ff[8] |=> ea_ff == {bank_ff, $past(f_adr)})
    else $error("bank select address wrong");
  index_mode_a: assert property (
    state_ff == exec_pkg::ST_DECODE && !instr_ff[8] && ext_ff && f_adr <= 8'h5F
      |=> ea_ff == $past(index_ff) + {4'h0, $past(f_adr)})
    else $error("indexed address wrong");
  four_phase_a: assert property (
    state_ff == exec_pkg::ST_READ |-> ##1 state_ff == exec_pkg::ST_PROCESS
      ##1 state_ff == exec_pkg::ST_WRITE ##1 state_ff == exec_pkg::ST_IDLE)
    else $error("phase order broken");
  rotate_result_a: assert property (
    state_ff == exec_pkg::ST_PROCESS && op_ff == exec_pkg::OP_ROT
      |=> result_ff == {$past(operand_ff[0]), $past(operand_ff[7:1])})
    else $error("rotate result wrong");
  other_flags_a: assert property (
    state_ff == exec_pkg::ST_WRITE |=> status_ff[3] == $past(status_ff[3])
      && status_ff[1:0] == $past(status_ff[1:0]))
    else $error("unrelated flag changed");
  rot_decode_a: assert property (
    state_ff == exec_pkg::ST_DECODE && instr_ff[15:10] == 6'h10 |=> op_ff == exec_pkg::OP_ROT)
    else $error("rotate not decoded");
  dest_route_a: assert property (
    state_ff == exec_pkg::ST_WRITE && op_ff == exec_pkg::OP_ROT && !instr_ff[9]
      |-> !fp.we ##1 wreg_ff == $past(result_ff))
    else $error("working register not written");
  // access bank addresses up to 5Fh from page 0, those above 5Fh from page F
  access_bank_a: assert property (
    state_ff == exec_pkg::ST_DECODE && !instr_ff[8] && !ext_ff
      |=> ea_ff == {(($past(f_adr) <= 8'h5F) ? 4'h0 : 4'hF), $past(f_adr)})
    else $error("access bank not used");
  nz_flags_a: assert property (
    state_ff == exec_pkg::ST_WRITE && op_ff == exec_pkg::OP_ROT |=>
      status_ff[4] == $past(result_ff[7]) && status_ff[2] == ($past(result_ff) == 8'h00))
    else $error("negative or zero flag wrong");

  set_run_c: cover property (state_ff == exec_pkg::ST_WRITE && op_ff == exec_pkg::OP_SET);
  rot_w_c: cover property (state_ff == exec_pkg::ST_WRITE && op_ff == exec_pkg::OP_ROT
    && !instr_ff[9]);
  idx_c: cover property (state_ff == exec_pkg::ST_DECODE && ext_ff && !instr_ff[8]);
endmodule // set_and_rotate_exec
`default_nettype wire

// ---- pkg/exec_defines.svh ----
// register offsets, field positions, reset values and opcode patterns of the exec block
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

`define ADR_W 8
`define FILE_AW 12
`define OFS_INSTR 8'h00
`define OFS_WREG 8'h04
`define OFS_STATUS 8'h08
`define OFS_BANK 8'h0C
`define OFS_CTRL 8'h10
`define OFS_INDEX 8'h14
`define OFS_FADDR 8'h18
`define OFS_FDATA 8'h1C

`define ST_C_BIT 0
`define ST_DC_BIT 1
`define ST_Z_BIT 2
`define ST_OV_BIT 3
`define ST_N_BIT 4
`define ST_BUSY_BIT 8
`define ST_ILL_BIT 9
`define CTRL_EXT_BIT 0

`define RST_INSTR 16'h0000
`define RST_WREG 8'h00
`define RST_STATUS 5'h00
`define RST_BANK 4'h0
`define RST_INDEX 12'h000
`define RST_FADDR 12'h000

`define PAT_SET_ALL 7'h34
`define PAT_ROT_RIGHT 6'h10
`define ALL_ONES 8'hFF
`define INDEX_LIMIT 8'h5F
`define ACCESS_LOW_PAGE 4'h0
`define ACCESS_HIGH_PAGE 4'hF

`endif

// ---- pkg/exec_pkg.sv ----
// types shared by the exec block
package exec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_READ,
    ST_PROCESS,
    ST_WRITE
  } exec_state_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_SET,
    OP_ROT
  } exec_op_t;
endpackage

// ---- pkg/file_port_if.sv ----
// single port between the exec control and the file register store
`timescale 1ns/1ps
`default_nettype none
interface file_port_if #(parameter int AW = 12);
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output we, input rdata);
  modport store (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ---- rtl/file_regs.sv ----
// file register store: flip-flop array, combinational read, clocked write
`timescale 1ns/1ps
`default_nettype none
module file_regs #(
  parameter int AW = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  file_port_if.store fp
);
  logic [7:0] mem_ff [2**AW];

  assign fp.rdata = mem_ff[fp.addr];

  // contents are not cleared by reset, as in a real register file
  always_ff @(posedge clk_i) begin
    if (fp.we && !rst_i) begin
      mem_ff[fp.addr] <= fp.wdata;
    end
  end
endmodule // file_regs
`default_nettype wire

// ---- verif/set_and_rotate_exec_test.sv ----
// self-checking bench for the set-all-ones and rotate-right exec block
`timescale 1ns/1ps
`default_nettype none
`include "exec_defines.svh"
module set_and_rotate_exec_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic busy_o;
  int n_errors = 0;
  int cmp_count = 0;

  always #10 clk_i = ~clk_i;

  set_and_rotate_exec #(.FILE_AW(12)) set_and_rotate_exec_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy_o(busy_o)
  );

  task automatic report_and_stop;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; the answer is taken at the edge that sees ack high
  // no local limit: a missing ack is left to the watchdog
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 32'h00000000, q);
    check32(q, exp, what);
  endtask

  task automatic fput(input logic [11:0] a, input logic [7:0] v);
    wr(`OFS_FADDR, {20'h00000, a});
    wr(`OFS_FDATA, {24'h000000, v});
  endtask

  task automatic fchk(input logic [11:0] a, input logic [7:0] exp);
    wr(`OFS_FADDR, {20'h00000, a});
    rd_chk(`OFS_FDATA, {24'h000000, exp}, "file reg");
  endtask

  // busy count: illegal opcodes stop after decode, legal ones take all four phases
  task automatic run(input logic [15:0] ins, input int exp_busy);
    int n;
    wr(`OFS_INSTR, {16'h0000, ins});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy_o === 1'b1 && n < 20);
    check32(n - 1, exp_busy, "busy cycles");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("ERROR %0t watchdog", $time);
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'(4 * i), 32'h00000000, "reset value");
    end
    wr(8'h20, 32'h12345678);
    rd_chk(8'h20, 32'h00000000, "unmapped");
    // set, bank select chosen, access bank copy untouched
    wr(`OFS_BANK, 32'h00000002);
    fput(12'h234, 8'h5A);
    fput(12'h034, 8'h11);
    wr(`OFS_STATUS, 32'h0000000B);
    run(16'h6934, 4);
    fchk(12'h234, 8'hFF);
    fchk(12'h034, 8'h11);
    rd_chk(`OFS_STATUS, 32'h0000000B, "status after set");
    // set through the access bank, at or below 5Fh and above it
    run(16'h6834, 4);
    fchk(12'h034, 8'hFF);
    fput(12'hF80, 8'h00);
    run(16'h6880, 4);
    fchk(12'hF80, 8'hFF);
    // indexed mode up to the 5Fh boundary, not past it
    wr(`OFS_CTRL, 32'h00000001);
    wr(`OFS_INDEX, 32'h00000300);
    fput(12'h35F, 8'h00);
    run(16'h685F, 4);
    fchk(12'h35F, 8'hFF);
    fput(12'hF60, 8'h00);
    run(16'h6860, 4);
    fchk(12'hF60, 8'hFF);
    // a set access bit keeps the bank select even with indexing on; then an indexed rotate back to file
    fput(12'h230, 8'h00);
    fput(12'h330, 8'h00);
    run(16'h6930, 4);
    fchk(12'h230, 8'hFF);
    fchk(12'h330, 8'h00);
    fput(12'h320, 8'h02);
    run(16'h4220, 4);
    fchk(12'h320, 8'h01);
    wr(`OFS_CTRL, 32'h00000000);
    // rotate back to file via bank select, other flags kept
    fput(12'h240, 8'hAB);
    wr(`OFS_STATUS, 32'h0000000B);
    run(16'h4340, 4);
    fchk(12'h240, 8'hD5);
    rd_chk(`OFS_STATUS, 32'h0000001B, "status rot");
    rd_chk(`OFS_WREG, 32'h00000000, "w kept");
    // rotate to w, access bank overrides bank select
    fput(12'hF90, 8'h01);
    wr(`OFS_STATUS, 32'h00000004);
    run(16'h4090, 4);
    rd_chk(`OFS_WREG, 32'h00000080, "w rot");
    fchk(12'hF90, 8'h01);
    rd_chk(`OFS_STATUS, 32'h00000010, "status n");
    // zero result
    fput(12'h241, 8'h00);
    wr(`OFS_STATUS, 32'h00000010);
    run(16'h4141, 4);
    rd_chk(`OFS_WREG, 32'h00000000, "w zero");
    rd_chk(`OFS_STATUS, 32'h00000004, "status z");
    // neighbour opcode must not rotate; it leaves after decode alone
    fput(12'h242, 8'h02);
    wr(`OFS_STATUS, 32'h00000000);
    run(16'h4542, 1);
    fchk(12'h242, 8'h02);
    rd_chk(`OFS_STATUS, 32'h00000200, "illegal flag");
    // writing one to the illegal bit clears it
    wr(`OFS_STATUS, 32'h00000200);
    rd_chk(`OFS_STATUS, 32'h00000000, "illegal cleared");
    report_and_stop();
  end
endmodule // set_and_rotate_exec_test
`default_nettype wire
